// ### common/fsps_pkg.sv
// Constants shared by the flash self-programming sequencer
package fsps_pkg;
  // Pointer layout: page field above the word offset field
  localparam int PAGE_W     = 10;
  localparam int WORD_W     = 5;
  localparam int Z_PAGE_LSB = 6;
  localparam int Z_WORD_LSB = 1;
  localparam int BUF_DEPTH  = 32;
  // Control and status register bit positions
  localparam int BIT_EN     = 0;
  localparam int BIT_ERASE  = 1;
  localparam int BIT_WRITE  = 2;
  localparam int BIT_LOCK   = 3;
  localparam int BIT_REEN   = 4;
  localparam int BIT_SIG    = 5;
  localparam int BIT_IRQEN  = 7;
  // Command values in the low six control bits
  localparam logic [5:0] CMD_LOAD  = 6'h01;
  localparam logic [5:0] CMD_ERASE = 6'h03;
  localparam logic [5:0] CMD_WRITE = 6'h05;
  localparam logic [5:0] CMD_LOCK  = 6'h09;
  localparam logic [5:0] CMD_REEN  = 6'h11;
  // Timed windows: store within four cycles, load within three
  localparam logic [2:0] SPM_WIN      = 3'h4;
  localparam logic [2:0] LPM_WIN      = 3'h3;
  localparam logic [2:0] LPM_MIN_LEFT = 3'(SPM_WIN - LPM_WIN + 3'h1);
  // Pointer values that select the fuse and lock bytes
  localparam logic [15:0] Z_FUSE_LOW  = 16'h0000;
  localparam logic [15:0] Z_LOCK_BITS = 16'h0001;
  localparam logic [15:0] Z_FUSE_EXT  = 16'h0002;
  localparam logic [15:0] Z_FUSE_HIGH = 16'h0003;
  // Programming time: least 3.2 ms, longest 3.4 ms
  localparam int CLK_PERIOD_NS = 20;
  localparam int PROG_MIN_NS   = 3200000;
  localparam int PROG_MAX_NS   = 3400000;
  localparam int PROG_CYCLES   = (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_MAX_CYC  = PROG_MAX_NS / CLK_PERIOD_NS;
  localparam int TMR_W         = 18;
  // Unprogrammed lock bits read as one
  localparam logic [5:0] LOCK_RESET = 6'h3f;
  // First page of the section that cannot be read while writing
  localparam logic [PAGE_W-1:0] NO_READ_WHILE_WRITE_SECTION_PAGE_START = 10'h380;
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_PROG} fsps_state_t;
endpackage

// ### src/fsps_sequencer.sv
// Flash self-programming sequencer: timed command, page buffer, lock and fuse reads
//
// Overview of operation
// - Erase command then store within four cycles erases the pointer's page.
// - Erase ignores the data pair and pointer bits outside the page field.
// - Load command then store writes the data pair at word offset bits 5..1.
// - Page buffer clears after page write, re-enable write, and reset.
// - An EEPROM write during page loading discards all loaded words.
// - Write command then store programs the buffer into the pointer's page.
// - Erase or write to the no-read-while-write section halts the core.
// - Reads of the read-while-write section are blocked during erase/write.
// - Busy flag stays set while the read-while-write section is unavailable.
// - Re-enable command then store clears the busy flag.
// - With interrupt enabled, request stands while the enable bit is zero.
// - Lock-set command plus store programs lock bits whose data bit is zero.
// - Lock programming leaves the whole flash readable without stall.
// - While an EEPROM write runs, commands and fuse/lock reads are rejected.
// - Lock-set and enable, pointer one, load within three returns lock byte.
// - Lock-set and enable self-clear after read or missed windows.
// - Pointer zero returns fuse low byte; bits clear give ordinary reads.
// - Pointer three returns fuse high byte, pointer two the extended byte.
// - Each erase, write or lock write lasts 3.2 to 3.4 ms.
`timescale 1ns/10ps
`default_nettype none
module fsps_sequencer
#(
  parameter int PROG_CYC = fsps_pkg::PROG_CYCLES
)
(
  input  wire logic                        mclk,
  input  wire logic                        resetn,
  input  wire logic                        clk_en,
  input  wire logic                        csr_we,
  input  wire logic [7:0]                  csr_wdata,
  input  wire logic                        spm_exec,
  input  wire logic                        lpm_exec,
  input  wire logic [15:0]                 z_ptr,
  input  wire logic [15:0]                 data_register_pair,
  input  wire logic                        eeprom_write_busy_flag,
  input  wire logic [7:0]                  fuse_low_byte,
  input  wire logic [7:0]                  fuse_high_byte,
  input  wire logic [3:0]                  fuse_extended_byte,
  input  wire logic [fsps_pkg::WORD_W-1:0] buf_rd_idx,
  output logic      [7:0]                  self_prog_ctrl_status,
  output logic                             cpu_halt,
  output logic                             rww_read_block,
  output logic                             spm_irq,
  output logic                             lpm_override,
  output logic      [7:0]                  lpm_data,
  output logic                             prog_erase,
  output logic                             prog_write,
  output logic                             prog_lock,
  output logic      [fsps_pkg::PAGE_W-1:0] prog_page,
  output logic      [5:0]                  lock_bits,
  output logic      [15:0]                 buf_rd_data,
  output logic                             buf_rd_valid
);
  import fsps_pkg::*;

  fsps_state_t              state;
  logic [5:0]               cmd;
  logic                     irq_en;
  logic [2:0]               win;
  logic [TMR_W-1:0]         timer;
  logic [5:0]               lock_mask;
  logic [15:0]              buf_mem [BUF_DEPTH];
  logic [BUF_DEPTH-1:0]     buf_vld;

  // Decode of the pointer and the armed command
  wire [PAGE_W-1:0] z_page   = z_ptr[Z_PAGE_LSB +: PAGE_W];
  wire [WORD_W-1:0] z_word   = z_ptr[Z_WORD_LSB +: WORD_W];
  wire              ee_busy  = eeprom_write_busy_flag;
  wire              armed    = (state == ST_ARMED);
  wire              spm_go   = clk_en && armed && spm_exec && !ee_busy;
  wire              is_erase = (cmd == CMD_ERASE);
  wire              is_write = (cmd == CMD_WRITE);
  wire              lpm_go   = clk_en && armed && lpm_exec && !ee_busy
                               && (cmd == CMD_LOCK) && (win >= LPM_MIN_LEFT);
  wire              timeout  = clk_en && armed && (win == 3'h1) && !spm_go && !lpm_go;
  wire              prog_end = clk_en && (state == ST_PROG) && (timer == '0);
  // Buffer clears: write done, re-enable, EEPROM write while words are loaded
  wire              buf_clr  = (prog_end && prog_write)
                               || (spm_go && cmd == CMD_REEN)
                               || (clk_en && ee_busy && (|buf_vld));
  wire              csr_take = clk_en && csr_we && (state == ST_IDLE) && !ee_busy;
  wire              no_read_while_write_section_hit = (z_page >= NO_READ_WHILE_WRITE_SECTION_PAGE_START);
  wire [7:0]        rd_sel   = (z_ptr == Z_LOCK_BITS) ? {2'b11, lock_bits}
                             : (z_ptr == Z_FUSE_LOW)  ? fuse_low_byte
                             : (z_ptr == Z_FUSE_HIGH) ? fuse_high_byte
                             : {4'hf, fuse_extended_byte};
  wire              rd_hit   = (z_ptr[15:2] == '0);

  // Status view: every bit is a flip-flop
  assign self_prog_ctrl_status = {irq_en, rww_read_block, cmd};

  // Command arming and the timed window; EEPROM busy blocks arming
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      state <= ST_IDLE;
      cmd   <= '0;
      win   <= '0;
    end
    else if (clk_en)
    begin
      if (csr_take && csr_wdata[BIT_EN])
      begin
        state <= ST_ARMED;
        cmd   <= csr_wdata[5:0];
        win   <= SPM_WIN;
      end
      else if (spm_go && (is_erase || is_write || cmd == CMD_LOCK))
        state <= ST_PROG;
      else if (spm_go || lpm_go || timeout || prog_end)
      begin
        state <= ST_IDLE;
        cmd   <= '0;
        win   <= '0;
      end
      else if (armed)
        win <= win - 3'h1;
    end
  end

  // Interrupt enable is writable at any time, request is a level
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      irq_en  <= 1'b0;
      spm_irq <= 1'b0;
    end
    else if (clk_en)
    begin
      if (csr_we)
        irq_en <= csr_wdata[BIT_IRQEN];
      spm_irq <= irq_en && !cmd[BIT_EN];
    end
  end

  // Operation timer; counts the programming time in core cycles
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      timer <= '0;
    else if (clk_en)
    begin
      if (spm_go)
        timer <= TMR_W'(PROG_CYC - 1);
      else if (timer != '0)
        timer <= timer - 1'b1;
    end
  end

  // Flash operation strobes, target page, halt and read blocking
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      prog_erase     <= 1'b0;
      prog_write     <= 1'b0;
      prog_lock      <= 1'b0;
      prog_page      <= '0;
      cpu_halt       <= 1'b0;
      rww_read_block <= 1'b0;
    end
    else if (clk_en)
    begin
      if (spm_go && (is_erase || is_write))
      begin
        prog_erase     <= is_erase;
        prog_write     <= is_write;
        prog_page      <= z_page;
        cpu_halt       <= no_read_while_write_section_hit;
        rww_read_block <= 1'b1;
      end
      else if (spm_go && cmd == CMD_LOCK)
        prog_lock <= 1'b1;
      else if (prog_end)
      begin
        prog_erase <= 1'b0;
        prog_write <= 1'b0;
        prog_lock  <= 1'b0;
        cpu_halt   <= 1'b0;
      end
      else if (spm_go && cmd == CMD_REEN)
        rww_read_block <= 1'b0;
    end
  end

  // Lock bits: only zero data bits program, applied when the time is over
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      lock_mask <= LOCK_RESET;
      lock_bits <= LOCK_RESET;
    end
    else if (clk_en)
    begin
      if (spm_go && cmd == CMD_LOCK)
        lock_mask <= data_register_pair[5:0];
      else if (prog_end && prog_lock)
        lock_bits <= lock_bits & lock_mask;
    end
  end

  // Temporary page buffer; a clear wins over a load in the same cycle
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      buf_vld <= '0;
    else if (clk_en)
    begin
      if (buf_clr)
        buf_vld <= '0;
      else if (spm_go && cmd == CMD_LOAD)
      begin
        buf_vld[z_word] <= 1'b1;
        buf_mem[z_word] <= data_register_pair;
      end
    end
  end

  // Buffer read port towards the flash array
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      buf_rd_data  <= '0;
      buf_rd_valid <= 1'b0;
    end
    else if (clk_en)
    begin
      buf_rd_data  <= buf_mem[buf_rd_idx];
      buf_rd_valid <= buf_vld[buf_rd_idx];
    end
  end

  // Lock and fuse byte reads; other pointers fall back to ordinary reads
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      lpm_override <= 1'b0;
      lpm_data     <= '0;
    end
    else if (clk_en)
    begin
      lpm_override <= lpm_go && rd_hit;
      if (lpm_go && rd_hit)
        lpm_data <= rd_sel;
    end
  end

  // Checks
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_erase_page_latch: assert property (
    spm_go && is_erase |=> prog_erase && prog_page == $past(z_page))
    else $error("erase did not latch the page");

  a_load_word_mark: assert property (
    spm_go && cmd == CMD_LOAD && !buf_clr |=> buf_vld[$past(z_word)])
    else $error("loaded word not marked");

  a_buf_reenable_clr: assert property (
    spm_go && cmd == CMD_REEN |=> buf_vld == '0 && !rww_read_block)
    else $error("re-enable left buffer or busy");

  a_ee_discard_buf: assert property (
    clk_en && ee_busy |=> buf_vld == '0)
    else $error("buffer kept during EEPROM write");

  a_no_read_while_write_section_halt_cpu: assert property (
    spm_go && (is_erase || is_write) && no_read_while_write_section_hit |=> cpu_halt && rww_read_block)
    else $error("no halt for protected section");

  a_busy_flag_hold: assert property (
    rww_read_block && !(spm_go && cmd == CMD_REEN) |=> rww_read_block)
    else $error("busy flag dropped early");

  a_irq_level_on: assert property (
    clk_en && irq_en && !cmd[BIT_EN] |=> spm_irq)
    else $error("interrupt missing while idle");

  a_lock_no_stall: assert property (
    prog_lock |-> !cpu_halt && !prog_erase && !prog_write)
    else $error("lock write stalls reads");

  a_ee_reject_cmd: assert property (
    clk_en && ee_busy && state == ST_IDLE |=> state == ST_IDLE)
    else $error("command armed during EEPROM write");

  a_lock_byte_read: assert property (
    lpm_go && z_ptr == Z_LOCK_BITS |=> lpm_override && lpm_data[5:0] == $past(lock_bits))
    else $error("lock byte not returned");

  a_window_expire: assert property (
    timeout |=> state == ST_IDLE && cmd == '0)
    else $error("command survived its window");

  a_prog_time_run: assert property (
    clk_en && state == ST_PROG && timer != '0 |=> state == ST_PROG && cmd[BIT_EN])
    else $error("operation ended early");
endmodule
`default_nettype wire

// ### tb/fsps_core_model.sv
// Core model issuing timed control writes and store or load instructions
`timescale 1ns/10ps
`default_nettype none
module fsps_core_model
(
  input  wire logic        mclk,
  input  wire logic        eeprom_write_busy_flag,
  output logic             csr_we,
  output logic [7:0]       csr_wdata,
  output logic             spm_exec,
  output logic             lpm_exec,
  output logic [15:0]      z_ptr,
  output logic [15:0]      data_register_pair
);
  // Quiet bus at time zero
  initial
  begin
    csr_we = 1'b0;
    csr_wdata = 8'h00;
    spm_exec = 1'b0;
    lpm_exec = 1'b0;
    z_ptr = 16'h0000;
    data_register_pair = 16'h0000;
  end
  // Control write, then the instruction gap clock edges later
  task automatic op(input logic [7:0] wd, input logic [15:0] z, input logic [15:0] d,
                    input int gap, input logic ld, input logic ee_wait);
    // Poll EEPROM busy first unless a refusal is wanted
    while (ee_wait && eeprom_write_busy_flag === 1'b1)
      @(posedge mclk);
    @(posedge mclk);
    csr_we <= 1'b1;
    csr_wdata <= wd;
    z_ptr <= z;
    data_register_pair <= d;
    @(posedge mclk);
    csr_we <= 1'b0;
    repeat (gap - 1) @(posedge mclk);
    if (ld)
      lpm_exec <= 1'b1;
    else
      spm_exec <= 1'b1;
    @(posedge mclk);
    spm_exec <= 1'b0;
    lpm_exec <= 1'b0;
    // Released operands stop showing their value
    z_ptr <= ~z;
    data_register_pair <= ~d;
  endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the flash self-programming sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import fsps_pkg::*;
  localparam int PC = 8;
  logic        mclk, resetn, ee, we, se, le, halt, blk, irq, ovr, per, pwr, plk, bval, ce;
  logic [7:0]  wd, st, lpd, flo, fhi;
  logic [3:0]  fext;
  logic [4:0]  bidx;
  logic [9:0]  pg, p, pr;
  logic [5:0]  lockb, lockm;
  logic [15:0] z, d, bdat;
  logic [15:0] bufm [BUF_DEPTH];
  logic [31:0] seed;
  int          n_errors, tests_run, cyc;
  fsps_sequencer #(.PROG_CYC(PC)) fsps_sequencer_i (.mclk(mclk), .resetn(resetn),
    .clk_en(ce), .csr_we(we), .csr_wdata(wd), .spm_exec(se), .lpm_exec(le), .z_ptr(z),
    .data_register_pair(d), .eeprom_write_busy_flag(ee), .fuse_low_byte(flo),
    .fuse_high_byte(fhi), .fuse_extended_byte(fext), .buf_rd_idx(bidx),
    .self_prog_ctrl_status(st), .cpu_halt(halt), .rww_read_block(blk), .spm_irq(irq),
    .lpm_override(ovr), .lpm_data(lpd), .prog_erase(per), .prog_write(pwr),
    .prog_lock(plk), .prog_page(pg), .lock_bits(lockb), .buf_rd_data(bdat),
    .buf_rd_valid(bval));
  fsps_core_model fsps_core_model_i (.mclk(mclk), .eeprom_write_busy_flag(ee),
    .csr_we(we), .csr_wdata(wd), .spm_exec(se), .lpm_exec(le), .z_ptr(z),
    .data_register_pair(d));
  // Clock and a hang guard well above the expected run
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim;
    if (n_errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] exp_rd(input int a);
    case (a)
      0: return flo;
      1: return {2'b11, lockm};
      2: return {4'hf, fext};
      default: return fhi;
    endcase
  endfunction
  task automatic tick;
    @(posedge mclk);
    #1;
  endtask
  // Wait, bounded, for the enable bit to drop
  task automatic idle;
    int n;
    n = 0;
    tick();
    while (st[BIT_EN] === 1'b1 && n < 50)
    begin
      n++;
      tick();
    end
  endtask
  // Operation start, hold time and completion
  task automatic prog(input int w, input logic [9:0] pp, input logic h, input logic iq);
    int n;
    tick();
    chk("prog", (w == 0) ? per : (w == 1) ? pwr : plk, 1'b1);
    if (w < 2) chk("page", pg, pp);
    chk("halt", halt, h);
    chk("block", blk, w < 2);
    chk("enable", st[BIT_EN], 1'b1);
    n = 0;
    while (st[BIT_EN] === 1'b1 && n < 50)
    begin
      n++;
      tick();
    end
    chk("duration", 16'(n + 1), 16'(PC));
    chk("halt_end", halt, 1'b0);
    tick();
    chk("irq", irq, iq);
    chk("block_end", blk, w < 2);
  endtask
  task automatic reen;
    fsps_core_model_i.op({2'b00, CMD_REEN}, 16'h0000, 16'h0000, 2, 1'b0, 1'b1);
    idle();
    tick();
    chk("block_clr", blk, 1'b0);
  endtask
  // Distinct word per load, random gap
  task automatic load(input logic [4:0] i);
    seed = lfsr(seed);
    bufm[i] = seed[31:16];
    fsps_core_model_i.op({2'b00, CMD_LOAD}, {seed[9:0], i, 1'b0}, seed[31:16],
                         1 + int'(seed[1:0]), 1'b0, 1'b1);
    idle();
  endtask
  task automatic chkbuf(input logic [4:0] i, input logic v);
    @(posedge mclk);
    bidx <= i;
    repeat (2) @(posedge mclk);
    #1;
    chk("buf_valid", bval, v);
    if (v) chk("buf_data", bdat, bufm[i]);
  endtask
  initial
  begin
    resetn = 1'b0;
    ee = 1'b0;
    ce = 1'b1;
    bidx = 5'h00;
    seed = 32'h26cd6a9f;
    {flo, fhi, fext} = seed[19:0];
    n_errors = 0;
    tests_run = 0;
    cyc = 0;
    lockm = LOCK_RESET;
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    #1;
    chk("rst_status", st, 8'h00);
    chk("rst_lock", lockb, LOCK_RESET);
    // Erase a plain page then a halting page, junk in ignored operands
    for (int k = 0; k < 2; k++)
    begin
      seed = lfsr(seed);
      p = k ? (10'h380 | 10'(seed[6:0])) : {1'b0, seed[8:0]};
      if (k == 0) pr = p;
      fsps_core_model_i.op({2'b10, CMD_ERASE}, {p, seed[21:16]}, seed[31:16],
                           1 + int'(seed[1:0]), 1'b0, 1'b1);
      prog(0, p, k[0], 1'b1);
      reen();
    end
    for (int i = 0; i < 6; i++) load(5'((i * 7 + 3) % 32));
    chkbuf(5'd3, 1'b1);
    chkbuf(5'd17, 1'b1);
    chkbuf(5'd4, 1'b0);
    // Page write to the erased page, other pointer bits zero
    fsps_core_model_i.op({2'b00, CMD_WRITE}, {pr, 6'h00}, 16'hffff, 4, 1'b0, 1'b1);
    prog(1, pr, 1'b0, 1'b0);
    chkbuf(5'd3, 1'b0);
    reen();
    load(5'd5);
    reen();
    chkbuf(5'd5, 1'b0);
    // Lock programming, advised pointer and upper bits
    seed = lfsr(seed);
    fsps_core_model_i.op({2'b00, CMD_LOCK}, 16'h0001, {8'h00, 2'b11, seed[5:0]}, 3, 1'b0,
                         1'b1);
    lockm = lockm & seed[5:0];
    prog(2, 10'h000, 1'b0, 1'b0);
    chk("lock_bits", lockb, lockm);
    // Fuse and lock reads, then an unselected pointer
    for (int a = 0; a < 5; a++)
    begin
      seed = lfsr(seed);
      fsps_core_model_i.op({2'b00, CMD_LOCK}, 16'(a), 16'h0000, 1 + int'(seed[1:0]) % 3,
                           1'b1, 1'b1);
      // Override is a one-cycle pulse: look right after the load edge
      #1;
      chk("override", ovr, a < 4);
      if (a < 4) chk("rd_byte", lpd, exp_rd(a));
      tick();
      chk("rd_clr", st[5:0], 6'h00);
    end
    // Missed windows start nothing
    fsps_core_model_i.op({2'b00, CMD_ERASE}, 16'h0040, 16'h0000, 5, 1'b0, 1'b1);
    tick();
    chk("late_spm", {per, st[5:0]}, 7'h00);
    fsps_core_model_i.op({2'b00, CMD_LOCK}, 16'h0001, 16'h0000, 4, 1'b1, 1'b1);
    #1;
    chk("late_lpm", {ovr, st[5:0]}, 7'h00);
    // Frozen clock enable: a whole load sequence must leave no trace
    @(posedge mclk);
    ce <= 1'b0;
    fsps_core_model_i.op({2'b10, CMD_LOAD}, 16'h0018, 16'h1234, 1, 1'b0, 1'b1);
    tick();
    chk("freeze_st", st, 8'h00);
    ce <= 1'b1;
    chkbuf(5'd12, 1'b0);
    // EEPROM write drops loaded words and blocks commands
    load(5'd9);
    @(posedge mclk);
    ee <= 1'b1;
    @(posedge mclk);
    ee <= 1'b0;
    chkbuf(5'd9, 1'b0);
    ee <= 1'b1;
    fsps_core_model_i.op({2'b00, CMD_ERASE}, 16'h0040, 16'h0000, 1, 1'b0, 1'b0);
    tick();
    chk("ee_spm", {per, st[5:0]}, 7'h00);
    fsps_core_model_i.op({2'b00, CMD_LOCK}, 16'h0001, 16'h0000, 1, 1'b1, 1'b0);
    #1;
    chk("ee_lpm", ovr, 1'b0);
    ee <= 1'b0;
    // Second reset empties the buffer
    load(5'd2);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    chkbuf(5'd2, 1'b0);
    chk("rst2_lock", lockb, LOCK_RESET);
    end_sim();
  end
endmodule
`default_nettype wire
